// ==== design/sww_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the sleep/watchdog block
`ifndef SWW_REGS_VH
`define SWW_REGS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SWW_OFF_STATUS 12'h000
`define SWW_OFF_INTCTL 12'h004
`define SWW_OFF_OPTION 12'h008
`define SWW_OFF_PERIPHERAL_IRQ_ENABLE_2 12'h00C
`define SWW_OFF_PERIPHERAL_IRQ_FLAGS_2 12'h010
`define SWW_OFF_CORE 12'h014
`define SWW_OFF_EVENT 12'h018
`define SWW_OFF_WDCNT 12'h01C

// ------------------------------------------------------------
// core_status_flags fields
// ------------------------------------------------------------
`define SWW_ST_TO 4
`define SWW_ST_PD 3
`define SWW_ST_RST 8'h18

// ------------------------------------------------------------
// interrupt_control fields
// ------------------------------------------------------------
`define SWW_IC_GIE 7
`define SWW_IC_PERIPHERAL_IRQ_ENABLE 6
`define SWW_IC_T0IE 5
`define SWW_IC_INTE 4
`define SWW_IC_IOCE 3
`define SWW_IC_T0IF 2
`define SWW_IC_INTF 1
`define SWW_IC_IOCF 0
`define SWW_IC_RST 8'h00

// ------------------------------------------------------------
// timer_option_config fields
// ------------------------------------------------------------
`define SWW_OP_PSA 3
`define SWW_OP_RST 8'hFF
`define SWW_PERIPHERAL_IRQ_ENABLE_2_MASK 8'hDF

// ------------------------------------------------------------
// Core control bits (register at SWW_OFF_CORE, write pulses)
// ------------------------------------------------------------
`define SWW_CC_SLEEP 0
`define SWW_CC_CLEAR_WATCHDOG_INSTR 1

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SWW_CLK_MHZ 250
`define SWW_WDT_MS 18
`define SWW_WDT_CYC (`SWW_WDT_MS * 1000 * `SWW_CLK_MHZ)

`endif

// ==== design/sww_wdog.v ====
// Watchdog counter with optional shared prescaler
`timescale 1ns/1ps
`default_nettype none

module sww_wdog #(
    parameter BASE_CYC = 32'd4500000
) (
    input wire hclk,
    input wire hresetn,
    input wire enable,
    input wire clear,
    input wire prescaler_assign_select,
    input wire [2:0] ps_sel,
    output reg timeout
);

    reg [31:0] base_r;
    reg [6:0] pre_r;
    wire base_tick;
    wire pre_done;

    assign base_tick = (base_r == BASE_CYC - 32'd1);
    // Prescaler divides by 2^ps_sel when assigned to the watchdog
    assign pre_done = !prescaler_assign_select || (pre_r == ((7'd1 << ps_sel) - 7'd1));

    // ------------------------------------------------------------
    // Counting; clear restarts both base count and prescaler
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            base_r <= 32'd0;
            pre_r <= 7'd0;
            timeout <= 1'b0;
        end
        else if (clear || !enable)
        begin
            base_r <= 32'd0;
            pre_r <= 7'd0;
            timeout <= 1'b0;
        end
        else
        begin
            timeout <= 1'b0;
            if (base_tick)
            begin
                base_r <= 32'd0;
                if (pre_done)
                begin
                    pre_r <= 7'd0;
                    timeout <= 1'b1;
                end
                else
                    pre_r <= pre_r + 7'd1;
            end
            else
                base_r <= base_r + 32'd1;
        end
    end

endmodule // sww_wdog

`default_nettype wire

// ==== design/sww_top.v ====
// Sleep, wake-up and watchdog controller with AHB-Lite register slave
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sww_regs.vh"

module sww_top #(
    parameter WDT_CYC = `SWW_WDT_CYC
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire watchdog_enable_fuse,
    input wire master_clear_pin_n,
    input wire master_clear_enable,
    input wire por_event,
    input wire ext_irq_pin,
    input wire ioc_event,
    input wire [7:0] pin_out_in,
    input wire [7:0] pin_oe_n_in,
    input wire [7:0] analog_en_in,
    output reg cpu_clk_en,
    output reg core_reset,
    output reg irq_vector,
    output reg prefetch_next,
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe_n,
    output reg [7:0] analog_power,
    output reg [7:0] analog_en_hold,
    output reg asleep
);

    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    localparam ST_RUN = 3'b001;
    localparam ST_SLEEP = 3'b010;
    localparam ST_WAKE = 3'b100;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [7:0] status_r;
    reg [7:0] intctl_r;
    reg [7:0] option_r;
    reg [7:0] peripheral_irq_enable_2_r;
    reg [7:0] peripheral_irq_flags_2_r;
    reg fuse_r;
    reg fuse_seen_r;
    reg master_clear_pin_s1_r, master_clear_pin_s2_r;
    reg por_s1_r, por_s2_r;
    reg ext_s1_r, ext_s2_r, ext_d_r;
    reg ioc_s1_r, ioc_s2_r;
    reg wr_pend_r;
    reg [11:0] wr_addr_r;
    reg sleep_cmd_r;
    reg clear_watchdog_instr_cmd_r;
    wire wd_timeout;
    wire wd_clear;
    wire irq_pend;
    wire ext_rise;
    wire master_clear_pin_rst;
    wire sleep_enter;
    wire sleep_nop;
    wire [7:0] rdata_nxt;

    // Byte offset decode, shared by read and write paths
    function is_reg;
        input [11:0] a;
        input [11:0] off;
        begin
            is_reg = (a[11:2] == off[11:2]);
        end
    endfunction

    // ------------------------------------------------------------
    // Synchronisers for pins; first stage read only by the second
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            master_clear_pin_s1_r <= 1'b1;
            master_clear_pin_s2_r <= 1'b1;
            por_s1_r <= 1'b0;
            por_s2_r <= 1'b0;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_d_r <= 1'b0;
            ioc_s1_r <= 1'b0;
            ioc_s2_r <= 1'b0;
        end
        else
        begin
            master_clear_pin_s1_r <= master_clear_pin_n;
            master_clear_pin_s2_r <= master_clear_pin_s1_r;
            por_s1_r <= por_event;
            por_s2_r <= por_s1_r;
            ext_s1_r <= ext_irq_pin;
            ext_s2_r <= ext_s1_r;
            ext_d_r <= ext_s2_r;
            ioc_s1_r <= ioc_event;
            ioc_s2_r <= ioc_s1_r;
        end
    end

    assign ext_rise = ext_s2_r && !ext_d_r;
    // Reset pin acts identically awake or asleep
    assign master_clear_pin_rst = master_clear_enable && !master_clear_pin_s2_r;

    // ------------------------------------------------------------
    // Fuse capture after reset release; once cleared it stays off
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fuse_r <= 1'b1;
            fuse_seen_r <= 1'b0;
        end
        else if (!fuse_seen_r)
        begin
            fuse_r <= watchdog_enable_fuse;
            fuse_seen_r <= 1'b1;
        end
    end

    // Only individually enabled sources can wake, whatever global says
    assign irq_pend = (intctl_r[`SWW_IC_INTE] && intctl_r[`SWW_IC_INTF]) ||
                      (intctl_r[`SWW_IC_IOCE] && intctl_r[`SWW_IC_IOCF]);
    // Pending enabled interrupt turns sleep into a no-op
    assign sleep_nop = sleep_cmd_r && irq_pend;
    assign sleep_enter = sleep_cmd_r && !irq_pend && (state_r == ST_RUN);

    // Clear instruction, sleep entry and wake-up all restart the watchdog
    // Reset wakes skip the wake state, so a sleep exit is caught here as well
    assign wd_clear = clear_watchdog_instr_cmd_r || sleep_enter || (state_r == ST_WAKE) ||
                      ((state_r == ST_SLEEP) && (state_nxt != ST_SLEEP));

    sww_wdog #(
        .BASE_CYC(WDT_CYC)
    ) u_wdog (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(fuse_r),
        .clear(wd_clear),
        .prescaler_assign_select(option_r[`SWW_OP_PSA]),
        .ps_sel(option_r[2:0]),
        .timeout(wd_timeout)
    );

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
                if (sleep_enter)
                    state_nxt = ST_SLEEP;
            ST_SLEEP:
                // Late interrupts after entry wake at once; watchdog wakes too
                if (irq_pend || wd_timeout)
                    state_nxt = ST_WAKE;
            ST_WAKE:
                state_nxt = ST_RUN;
            default:
                state_nxt = ST_RUN;
        endcase
        // Power-on and pin resets restart from run, asleep or not
        if (por_s2_r || master_clear_pin_rst)
            state_nxt = ST_RUN;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_r <= ST_RUN;
        else
            state_r <= state_nxt;
    end

    // ------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cpu_clk_en <= 1'b1;
            core_reset <= 1'b1;
            irq_vector <= 1'b0;
            prefetch_next <= 1'b0;
            pin_out <= 8'h00;
            pin_oe_n <= 8'hFF;
            analog_power <= 8'h00;
            analog_en_hold <= 8'h00;
            asleep <= 1'b0;
        end
        else
        begin
            cpu_clk_en <= (state_nxt != ST_SLEEP);
            // Reset pulse: POR, pin, or watchdog while awake
            core_reset <= por_s2_r || master_clear_pin_rst ||
                          (wd_timeout && state_r == ST_RUN);
            // Vector only once the instruction after sleep has run
            irq_vector <= (state_r == ST_WAKE) && intctl_r[`SWW_IC_GIE] && irq_pend;
            prefetch_next <= sleep_enter;
            asleep <= (state_nxt == ST_SLEEP);
            // Freeze pin drive while asleep
            if (state_nxt != ST_SLEEP)
            begin
                pin_out <= pin_out_in;
                pin_oe_n <= pin_oe_n_in;
            end
            // Power gated off while asleep; analog_en_hold keeps following analog_en_in
            analog_en_hold <= analog_en_in;
            analog_power <= (state_nxt == ST_SLEEP) ? 8'h00 : analog_en_in;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave: address phase capture, zero wait states
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1])
                wr_addr_r <= haddr;
            if (hsel && hready && htrans[1] && !hwrite)
                hrdata <= {24'h000000, rdata_nxt};
        end
    end

    // Read mux; unmapped offsets read zero
    assign rdata_nxt = is_reg(haddr, `SWW_OFF_STATUS) ? status_r :
                       is_reg(haddr, `SWW_OFF_INTCTL) ? intctl_r :
                       is_reg(haddr, `SWW_OFF_OPTION) ? option_r :
                       is_reg(haddr, `SWW_OFF_PERIPHERAL_IRQ_ENABLE_2) ? peripheral_irq_enable_2_r :
                       is_reg(haddr, `SWW_OFF_PERIPHERAL_IRQ_FLAGS_2) ? peripheral_irq_flags_2_r :
                       is_reg(haddr, `SWW_OFF_EVENT) ? {5'h00, state_r} :
                       8'h00;

    // ------------------------------------------------------------
    // Registers; hardware sets win over software writes
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            status_r <= `SWW_ST_RST;
            intctl_r <= `SWW_IC_RST;
            option_r <= `SWW_OP_RST;
            peripheral_irq_enable_2_r <= 8'h00;
            peripheral_irq_flags_2_r <= 8'h00;
            sleep_cmd_r <= 1'b0;
            clear_watchdog_instr_cmd_r <= 1'b0;
        end
        else
        begin
            sleep_cmd_r <= 1'b0;
            clear_watchdog_instr_cmd_r <= 1'b0;
            if (wr_pend_r)
            begin
                if (is_reg(wr_addr_r, `SWW_OFF_STATUS))
                    status_r <= {hwdata[7:5], status_r[4:3], hwdata[2:0]};
                if (is_reg(wr_addr_r, `SWW_OFF_INTCTL))
                    intctl_r <= hwdata[7:0];
                if (is_reg(wr_addr_r, `SWW_OFF_OPTION))
                    option_r <= hwdata[7:0];
                if (is_reg(wr_addr_r, `SWW_OFF_PERIPHERAL_IRQ_ENABLE_2))
                    peripheral_irq_enable_2_r <= hwdata[7:0] & `SWW_PERIPHERAL_IRQ_ENABLE_2_MASK;
                if (is_reg(wr_addr_r, `SWW_OFF_PERIPHERAL_IRQ_FLAGS_2))
                    peripheral_irq_flags_2_r <= hwdata[7:0] & `SWW_PERIPHERAL_IRQ_ENABLE_2_MASK;
                if (is_reg(wr_addr_r, `SWW_OFF_CORE))
                begin
                    sleep_cmd_r <= hwdata[`SWW_CC_SLEEP] && !sleep_nop;
                    clear_watchdog_instr_cmd_r <= hwdata[`SWW_CC_CLEAR_WATCHDOG_INSTR];
                end
            end
            // Interrupt flags latch on events regardless of enables
            if (ext_rise)
                intctl_r[`SWW_IC_INTF] <= 1'b1;
            if (ioc_s2_r)
                intctl_r[`SWW_IC_IOCF] <= 1'b1;
            // Sleep entry: power-down flag low, time-out flag high
            if (sleep_enter)
            begin
                status_r[`SWW_ST_PD] <= 1'b0;
                status_r[`SWW_ST_TO] <= 1'b1;
            end
            // Clear instruction restores both flags high
            if (clear_watchdog_instr_cmd_r)
            begin
                status_r[`SWW_ST_PD] <= 1'b1;
                status_r[`SWW_ST_TO] <= 1'b1;
            end
            // Time-out dominates every other update of the TO flag
            if (wd_timeout)
                status_r[`SWW_ST_TO] <= 1'b0;
        end
    end

endmodule // sww_top

`default_nettype wire

// ==== sim/sww_top_sva.sv ====
// Assertion checker for the sleep, wake-up and watchdog block
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module sww_top_chk #(
    parameter WDT_CYC = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic master_clear_pin_n,
    input wire logic master_clear_enable,
    input wire logic por_event,
    input wire logic cpu_clk_en,
    input wire logic core_reset,
    input wire logic irq_vector,
    input wire logic prefetch_next,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] analog_power,
    input wire logic asleep
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Core frozen, pins held, analog cut while asleep
    a_sleep_clk_off: assert property (asleep |-> !cpu_clk_en)
        else $error("cpu clock running while asleep");
    a_sleep_power_cut: assert property (asleep |-> analog_power == 8'h00)
        else $error("analog power on while asleep");
    a_pins_held: assert property (asleep && $past(asleep) |-> $stable(pin_out) && $stable(pin_oe_n))
        else $error("pin state moved while asleep");
    // Entry and exit pulses
    a_prefetch_entry: assert property (prefetch_next |-> ##[0:2] asleep)
        else $error("prefetch without sleep entry");
    a_vector_pulse: assert property (irq_vector |=> !irq_vector)
        else $error("vector pulse longer than a cycle");
    a_wake_clk_back: assert property ($fell(asleep) |-> ##[0:2] cpu_clk_en)
        else $error("cpu clock not back after wake");
    // Synchronised resets act asleep or awake; margin covers the 2FF delay
    a_por_wakes: assert property (por_event [*5] |-> core_reset && !asleep)
        else $error("power-on event did not reset and wake");
    a_master_clear_pin_resets: assert property ((master_clear_enable && !master_clear_pin_n) [*5] |-> core_reset)
        else $error("enabled master clear did not reset");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
endmodule // sww_top_chk

bind sww_top sww_top_chk #(.WDT_CYC(WDT_CYC)) u_chk (.hclk, .hresetn, .hreadyout, .hresp,
    .master_clear_pin_n, .master_clear_enable, .por_event, .cpu_clk_en, .core_reset,
    .irq_vector, .prefetch_next, .pin_out, .pin_oe_n, .analog_power, .asleep);
`default_nettype wire

// ==== sim/sww_core_model.sv ====
// Behavioural core and interrupt source model facing the sleep block
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Core model
// ------------------------------------------------------------
module sww_core_model (
    input wire logic hclk,
    input wire logic irq_vector,
    input wire logic ext_req,
    input wire logic ioc_req,
    input wire logic [7:0] pat,
    output var logic ext_irq_pin,
    output var logic ioc_event,
    output var logic [7:0] pin_out_in,
    output var logic [7:0] pin_oe_n_in,
    output var logic [7:0] analog_en_in,
    output var logic [7:0] vec_count
);
    // Known levels from time zero
    initial
    begin
        ext_irq_pin = 1'b0;
        ioc_event = 1'b0;
        pin_out_in = 8'h00;
        pin_oe_n_in = 8'hFF;
        analog_en_in = 8'h00;
        vec_count = 8'h00;
    end
    // Pins keep changing so a missing freeze shows up
    // The word after sleep is a NOP here
    always @(posedge hclk)
    begin
        ext_irq_pin <= ext_req;
        ioc_event <= ioc_req;
        pin_out_in <= pat;
        pin_oe_n_in <= ~pat;
        analog_en_in <= pat ^ 8'h0F;
        if (irq_vector === 1'b1)
            vec_count <= vec_count + 8'h01;
    end
endmodule // sww_core_model
`default_nettype wire

// ==== sim/sww_top_tb.sv ====
// Self-checking testbench for the sleep, wake-up and watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "sww_regs.vh"
module sww_top_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic watchdog_enable_fuse, master_clear_pin_n, master_clear_enable, por_event;
    logic ext_irq_pin, ioc_event, ext_req, ioc_req;
    logic cpu_clk_en, core_reset, irq_vector, prefetch_next, asleep;
    logic [7:0] pin_out_in, pin_oe_n_in, analog_en_in, pin_out, pin_oe_n;
    logic [7:0] analog_power, analog_en_hold, pat, vec_count, q;
    int fail_count = 0;
    int cmp_count = 0;
    assign hready = hreadyout;
    sww_top #(.WDT_CYC(20)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .watchdog_enable_fuse,
        .master_clear_pin_n, .master_clear_enable, .por_event, .ext_irq_pin, .ioc_event,
        .pin_out_in, .pin_oe_n_in, .analog_en_in, .cpu_clk_en, .core_reset, .irq_vector,
        .prefetch_next, .pin_out, .pin_oe_n, .analog_power, .analog_en_hold, .asleep);
    sww_core_model u_core (.hclk, .irq_vector, .ext_req, .ioc_req, .pat, .ext_irq_pin,
        .ioc_event, .pin_out_in, .pin_oe_n_in, .analog_en_in, .vec_count);
    // ------------------------------------------------------------
    // Clock, checks and bus tasks
    // ------------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single word transfer; zero wait answers still go through the ready loop
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata[7:0];
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    // Bounded wait: 0 selects asleep, 1 selects core_reset
    task automatic wait_lv(input int sel, input logic v);
        logic s;
        for (int i = 0; i < 3000; i++)
        begin
            s = (sel == 0) ? asleep : core_reset;
            if (s === v) break;
            @(posedge hclk);
        end
        chk({7'h00, s}, {7'h00, v});
    endtask
    task automatic quiet(input int n);
        logic b;
        b = 1'b0;
        repeat (n)
        begin
            @(posedge hclk);
            if (core_reset !== 1'b0) b = 1'b1;
        end
        chk({7'h00, b}, 8'h00);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hang guard, over twenty times the expected run
    initial
    begin
        #80000;
        fail_count++;
        print_verdict;
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        hresetn <= 1'b0;
        hsel <= 1'b1;
        haddr <= 12'h000;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h00000000;
        watchdog_enable_fuse <= 1'b1;
        master_clear_pin_n <= 1'b1;
        master_clear_enable <= 1'b0;
        por_event <= 1'b0;
        ext_req <= 1'b0;
        ioc_req <= 1'b0;
        pat <= 8'hA5;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(`SWW_OFF_STATUS, 8'h18);
        rdc(`SWW_OFF_OPTION, 8'hFF);
        rdc(`SWW_OFF_WDCNT, 8'h00);
        wr(`SWW_OFF_PERIPHERAL_IRQ_ENABLE_2, 8'hFF);
        rdc(`SWW_OFF_PERIPHERAL_IRQ_ENABLE_2, 8'hDF);
        wr(`SWW_OFF_PERIPHERAL_IRQ_FLAGS_2, 8'hFF);
        rdc(`SWW_OFF_PERIPHERAL_IRQ_FLAGS_2, 8'hDF);
        wr(`SWW_OFF_STATUS, 8'h00);
        rdc(`SWW_OFF_STATUS, 8'h18);
        $display("test registers done");
        // Sleep, then wake on the external pin with vectoring off
        wr(`SWW_OFF_INTCTL, 8'h10);
        wr(`SWW_OFF_CORE, 8'h01);
        wait_lv(0, 1'b1);
        pat <= 8'h5A;
        repeat (4) @(posedge hclk);
        chk(pin_out, 8'hA5);
        chk(pin_oe_n, 8'h5A);
        chk(analog_power, 8'h00);
        chk(analog_en_hold, 8'h55);
        chk({7'h00, cpu_clk_en}, 8'h00);
        rdc(`SWW_OFF_STATUS, 8'h10);
        rdc(`SWW_OFF_EVENT, 8'h02);
        ext_req <= 1'b1;
        wait_lv(0, 1'b0);
        repeat (3) @(posedge hclk);
        chk(vec_count, 8'h00);
        chk(pin_out, 8'h5A);
        ext_req <= 1'b0;
        wr(`SWW_OFF_INTCTL, 8'h00);
        $display("test sleep and pin wake done");
        // Change wake with vectoring on
        wr(`SWW_OFF_INTCTL, 8'h88);
        wr(`SWW_OFF_CORE, 8'h01);
        wait_lv(0, 1'b1);
        ioc_req <= 1'b1;
        wait_lv(0, 1'b0);
        repeat (3) @(posedge hclk);
        chk(vec_count, 8'h01);
        ioc_req <= 1'b0;
        repeat (4) @(posedge hclk);
        wr(`SWW_OFF_INTCTL, 8'h00);
        $display("test change wake done");
        // Pending enabled flag turns sleep into a no-op
        wr(`SWW_OFF_CORE, 8'h02);
        // Command flags settle one cycle after the write lands
        @(posedge hclk);
        rdc(`SWW_OFF_STATUS, 8'h18);
        wr(`SWW_OFF_INTCTL, 8'h08);
        ioc_req <= 1'b1;
        repeat (4) @(posedge hclk);
        wr(`SWW_OFF_CORE, 8'h01);
        repeat (6) @(posedge hclk);
        chk({7'h00, asleep}, 8'h00);
        rdc(`SWW_OFF_STATUS, 8'h18);
        ioc_req <= 1'b0;
        repeat (4) @(posedge hclk);
        wr(`SWW_OFF_INTCTL, 8'h00);
        $display("test no-op sleep done");
        // Watchdog wakes a sleeper, then resets an awake core
        wr(`SWW_OFF_CORE, 8'h02);
        wr(`SWW_OFF_OPTION, 8'h00);
        wr(`SWW_OFF_CORE, 8'h01);
        wait_lv(0, 1'b1);
        ext_req <= 1'b1;
        repeat (6) @(posedge hclk);
        chk({7'h00, asleep}, 8'h01);
        wait_lv(0, 1'b0);
        rdc(`SWW_OFF_STATUS, 8'h00);
        wait_lv(1, 1'b1);
        ext_req <= 1'b0;
        $display("test watchdog done");
        // Long prescaled span, then switch the prescaler away mid-run
        wr(`SWW_OFF_INTCTL, 8'h00);
        wr(`SWW_OFF_OPTION, 8'hFF);
        wr(`SWW_OFF_CORE, 8'h02);
        wait_lv(1, 1'b0);
        quiet(200);
        wr(`SWW_OFF_OPTION, 8'h00);
        wait_lv(1, 1'b1);
        wr(`SWW_OFF_OPTION, 8'hFF);
        wr(`SWW_OFF_CORE, 8'h02);
        $display("test prescaler done");
        // Power-on event in sleep, then master clear
        wait_lv(1, 1'b0);
        wr(`SWW_OFF_CORE, 8'h01);
        wait_lv(0, 1'b1);
        por_event <= 1'b1;
        wait_lv(0, 1'b0);
        chk({7'h00, core_reset}, 8'h01);
        por_event <= 1'b0;
        wait_lv(1, 1'b0);
        master_clear_enable <= 1'b1;
        master_clear_pin_n <= 1'b0;
        wait_lv(1, 1'b1);
        master_clear_pin_n <= 1'b1;
        wait_lv(1, 1'b0);
        $display("test reset sources done");
        // Fuse cleared: watchdog never fires
        watchdog_enable_fuse <= 1'b0;
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        wr(`SWW_OFF_OPTION, 8'h00);
        quiet(300);
        $display("test fuse done");
        print_verdict;
    end
endmodule // sww_top_tb
`default_nettype wire
